/* File: logic/img_xfer.sv */
// Host image port unpacker and rectangle walker
`timescale 1ns/1ps
`default_nettype none
module img_xfer (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic reg_ready,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  output logic pix_valid,
  input wire logic pix_ready,
  output logic [15:0] pix_x,
  output logic [15:0] pix_y,
  output logic [31:0] pix_data,
  output logic pix_mono,
  output logic pix_mono_bit,
  output logic [15:0] pix_mix,
  output logic [15:0] pix_rop,
  output logic [15:0] pix_plane_mask
);
  function automatic logic [5:0] xfer_bits(input logic [1:0] w);
    case (w)
      img_xfer_pkg::XFER_BYTE: xfer_bits = img_xfer_pkg::BITS_8;
      img_xfer_pkg::XFER_WORD: xfer_bits = img_xfer_pkg::BITS_16;
      default: xfer_bits = img_xfer_pkg::BITS_32;
    endcase
  endfunction

  function automatic logic [5:0] depth_bits(input logic [1:0] d);
    case (d)
      img_xfer_pkg::DEPTH_4: depth_bits = img_xfer_pkg::BITS_4;
      img_xfer_pkg::DEPTH_8: depth_bits = img_xfer_pkg::BITS_8;
      img_xfer_pkg::DEPTH_16: depth_bits = img_xfer_pkg::BITS_16;
      default: depth_bits = img_xfer_pkg::BITS_32;
    endcase
  endfunction

  function automatic logic [31:0] low_mask(input logic [5:0] n);
    low_mask = (n >= img_xfer_pkg::BITS_32) ? ~img_xfer_pkg::RST_32 :
      ((32'h0000_0001 << n) - 32'h0000_0001);
  endfunction

  function automatic logic [31:0] rev_bytes(input logic [31:0] v);
    logic [31:0] r;
    r = img_xfer_pkg::RST_32;
    for (int i = 0; i < 32; i++)
      r[i] = v[(i / 8) * 8 + 7 - (i % 8)];
    rev_bytes = r;
  endfunction

  img_xfer_pkg::state_type state_ff, nxt_state;
  logic [15:0] cmd_ff, nxt_cmd, wmask_ff, nxt_wmask, mixsel_ff, nxt_mixsel;
  logic [15:0] fore_ff, nxt_fore, back_ff, nxt_back, rop_ff, nxt_rop;
  logic [31:0] size_ff, nxt_size, dest_ff, nxt_dest, curpos_ff, nxt_curpos;
  logic [1:0] depth_ff, nxt_depth;
  logic [31:0] buf_ff, nxt_buf;
  logic [5:0] avail_ff, nxt_avail;
  logic [15:0] xcnt_ff, nxt_xcnt, ycnt_ff, nxt_ycnt;
  logic pv_ff, nxt_pv, pmono_ff, nxt_pmono, pbit_ff, nxt_pbit;
  logic [15:0] px_ff, nxt_px, py_ff, nxt_py, pmix_ff, nxt_pmix;
  logic [31:0] pdata_ff, nxt_pdata, rdata_ff, nxt_rdata;
  logic rvalid_ff, nxt_rvalid;

  logic [1:0] width_sel;
  logic mono, busy, img_wr, cmd_wr, forbid, load, emit, line_end, last_px;
  logic [5:0] need, nbits, rem;
  logic [31:0] shifted;

  always_comb
  begin
    width_sel = cmd_ff[img_xfer_pkg::CMD_WIDTH_MSB:img_xfer_pkg::CMD_WIDTH_LSB];
    mono = cmd_ff[img_xfer_pkg::CMD_MULTI_BIT] && cmd_ff[img_xfer_pkg::CMD_WAIT_BIT] &&
      (mixsel_ff[img_xfer_pkg::MIXSEL_MSB:img_xfer_pkg::MIXSEL_LSB] ==
      img_xfer_pkg::MIXSEL_HOST);
    need = mono ? img_xfer_pkg::BITS_1 : depth_bits(depth_ff);
    nbits = xfer_bits(width_sel);
    busy = (state_ff == img_xfer_pkg::ST_RUN);
    img_wr = reg_wr && (reg_addr == img_xfer_pkg::ADDR_IMAGE);
    cmd_wr = reg_wr && (reg_addr == img_xfer_pkg::ADDR_CMD) && !busy;
    // Byte transfers cannot carry a whole 16 or 32 bpp pixel
    forbid = !(reg_wdata[img_xfer_pkg::CMD_MULTI_BIT]) &&
      (reg_wdata[img_xfer_pkg::CMD_WIDTH_MSB:img_xfer_pkg::CMD_WIDTH_LSB] ==
      img_xfer_pkg::XFER_BYTE) && depth_ff[1];
    load = busy && (avail_ff < need) && img_wr;
    reg_ready = !(img_wr && busy && (avail_ff >= need));
    emit = busy && (avail_ff >= need) && (!pv_ff || pix_ready);
    line_end = (xcnt_ff == size_ff[31:16]);
    last_px = line_end && (ycnt_ff == size_ff[15:0]);
    shifted = buf_ff >> need;
    rem = avail_ff - need;
  end

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cmd = cmd_ff;
    nxt_wmask = wmask_ff;
    nxt_mixsel = mixsel_ff;
    nxt_fore = fore_ff;
    nxt_back = back_ff;
    nxt_rop = rop_ff;
    nxt_size = size_ff;
    nxt_dest = dest_ff;
    nxt_depth = depth_ff;
    nxt_curpos = curpos_ff;
    nxt_buf = buf_ff;
    nxt_avail = avail_ff;
    nxt_xcnt = xcnt_ff;
    nxt_ycnt = ycnt_ff;
    nxt_pv = pv_ff && !pix_ready;
    nxt_pmono = pmono_ff;
    nxt_pbit = pbit_ff;
    nxt_px = px_ff;
    nxt_py = py_ff;
    nxt_pmix = pmix_ff;
    nxt_pdata = pdata_ff;
    nxt_rvalid = reg_rd;
    nxt_rdata = rdata_ff;
    if (reg_wr)
    begin
      case (reg_addr)
        img_xfer_pkg::ADDR_WMASK: nxt_wmask = reg_wdata[15:0];
        img_xfer_pkg::ADDR_MIXSEL: nxt_mixsel = reg_wdata[15:0];
        img_xfer_pkg::ADDR_FORE: nxt_fore = reg_wdata[15:0];
        img_xfer_pkg::ADDR_BACK: nxt_back = reg_wdata[15:0];
        img_xfer_pkg::ADDR_ROP: nxt_rop = reg_wdata[15:0];
        img_xfer_pkg::ADDR_DEPTH: nxt_depth = reg_wdata[1:0];
        img_xfer_pkg::ADDR_SIZE: nxt_size = reg_wdata;
        img_xfer_pkg::ADDR_DEST: nxt_dest = reg_wdata;
        default: ;
      endcase
    end
    if (cmd_wr)
    begin
      nxt_cmd = reg_wdata[15:0];
      // Only host-fed draws run here; screen copies finish at once
      if (reg_wdata[img_xfer_pkg::CMD_DRAW_BIT] && reg_wdata[img_xfer_pkg::CMD_WAIT_BIT] &&
        !forbid)
      begin
        nxt_state = img_xfer_pkg::ST_RUN;
        nxt_buf = img_xfer_pkg::RST_32;
        nxt_avail = 6'h00;
        nxt_xcnt = img_xfer_pkg::RST_16;
        nxt_ycnt = img_xfer_pkg::RST_16;
        nxt_curpos = dest_ff;
      end
    end
    if (load)
    begin
      // Mono bytes go in MSB first, so the stream always shifts right
      nxt_buf = buf_ff | (((mono ? rev_bytes(reg_wdata) : reg_wdata) & low_mask(nbits))
        << avail_ff);
      nxt_avail = avail_ff + nbits;
    end
    if (emit)
    begin
      nxt_pv = 1'b1;
      nxt_px = 16'(dest_ff[31:16] + xcnt_ff);
      nxt_py = 16'(dest_ff[15:0] + ycnt_ff);
      nxt_pdata = mono ? img_xfer_pkg::RST_32 : (buf_ff & low_mask(need));
      nxt_pmono = mono;
      nxt_pbit = buf_ff[0];
      nxt_pmix = (mono && !buf_ff[0]) ? back_ff : fore_ff;
      nxt_buf = shifted;
      nxt_avail = rem;
      nxt_xcnt = 16'(xcnt_ff + 16'h0001);
      if (line_end)
      begin
        nxt_xcnt = img_xfer_pkg::RST_16;
        nxt_ycnt = 16'(ycnt_ff + 16'h0001);
        if ((width_sel == img_xfer_pkg::XFER_PACK32) && !last_px)
        begin
          nxt_buf = shifted >> rem[2:0];
          nxt_avail = {rem[5:3], 3'b000};
        end
        else
        begin
          nxt_buf = img_xfer_pkg::RST_32;
          nxt_avail = 6'h00;
        end
      end
      if (last_px)
      begin
        nxt_state = img_xfer_pkg::ST_IDLE;
        if (width_sel == img_xfer_pkg::XFER_PACK32)
          nxt_curpos = {16'(dest_ff[31:16] + size_ff[31:16] + 16'h0001), dest_ff[15:0]};
        else
          nxt_curpos = {dest_ff[31:16], 16'(dest_ff[15:0] + size_ff[15:0] + 16'h0001)};
      end
    end
    if (reg_rd)
    begin
      case (reg_addr)
        img_xfer_pkg::ADDR_CMD:
        begin
          nxt_rdata = {16'h0000, cmd_ff};
          nxt_rdata[img_xfer_pkg::CMD_BUSY_BIT] = busy;
        end
        img_xfer_pkg::ADDR_WMASK: nxt_rdata = {16'h0000, wmask_ff};
        img_xfer_pkg::ADDR_MIXSEL: nxt_rdata = {16'h0000, mixsel_ff};
        img_xfer_pkg::ADDR_FORE: nxt_rdata = {16'h0000, fore_ff};
        img_xfer_pkg::ADDR_BACK: nxt_rdata = {16'h0000, back_ff};
        img_xfer_pkg::ADDR_ROP: nxt_rdata = {16'h0000, rop_ff};
        img_xfer_pkg::ADDR_DEPTH: nxt_rdata = {30'h0000_0000, depth_ff};
        img_xfer_pkg::ADDR_SIZE: nxt_rdata = size_ff;
        img_xfer_pkg::ADDR_DEST: nxt_rdata = dest_ff;
        img_xfer_pkg::ADDR_CURPOS: nxt_rdata = curpos_ff;
        default: nxt_rdata = img_xfer_pkg::RST_32;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_ff <= img_xfer_pkg::ST_IDLE;
      cmd_ff <= img_xfer_pkg::RST_16;
      wmask_ff <= img_xfer_pkg::RST_16;
      mixsel_ff <= img_xfer_pkg::RST_16;
      fore_ff <= img_xfer_pkg::RST_16;
      back_ff <= img_xfer_pkg::RST_16;
      rop_ff <= img_xfer_pkg::RST_16;
      size_ff <= img_xfer_pkg::RST_32;
      dest_ff <= img_xfer_pkg::RST_32;
      depth_ff <= img_xfer_pkg::DEPTH_4;
      curpos_ff <= img_xfer_pkg::RST_32;
      buf_ff <= img_xfer_pkg::RST_32;
      avail_ff <= 6'h00;
      xcnt_ff <= img_xfer_pkg::RST_16;
      ycnt_ff <= img_xfer_pkg::RST_16;
      pv_ff <= 1'b0;
      pmono_ff <= 1'b0;
      pbit_ff <= 1'b0;
      px_ff <= img_xfer_pkg::RST_16;
      py_ff <= img_xfer_pkg::RST_16;
      pmix_ff <= img_xfer_pkg::RST_16;
      pdata_ff <= img_xfer_pkg::RST_32;
      rdata_ff <= img_xfer_pkg::RST_32;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cmd_ff <= nxt_cmd;
      wmask_ff <= nxt_wmask;
      mixsel_ff <= nxt_mixsel;
      fore_ff <= nxt_fore;
      back_ff <= nxt_back;
      rop_ff <= nxt_rop;
      size_ff <= nxt_size;
      dest_ff <= nxt_dest;
      depth_ff <= nxt_depth;
      curpos_ff <= nxt_curpos;
      buf_ff <= nxt_buf;
      avail_ff <= nxt_avail;
      xcnt_ff <= nxt_xcnt;
      ycnt_ff <= nxt_ycnt;
      pv_ff <= nxt_pv;
      pmono_ff <= nxt_pmono;
      pbit_ff <= nxt_pbit;
      px_ff <= nxt_px;
      py_ff <= nxt_py;
      pmix_ff <= nxt_pmix;
      pdata_ff <= nxt_pdata;
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  assign pix_valid = pv_ff;
  assign pix_x = px_ff;
  assign pix_y = py_ff;
  assign pix_data = pdata_ff;
  assign pix_mono = pmono_ff;
  assign pix_mono_bit = pbit_ff;
  assign pix_mix = pmix_ff;
  assign pix_rop = rop_ff;
  assign pix_plane_mask = wmask_ff;
  assign reg_rdata = rdata_ff;
  assign reg_rvalid = rvalid_ff;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  sequence s_rect_done;
    emit && last_px;
  endsequence

  AST_LOAD_WIDTH: assert property (load |=> avail_ff == $past(avail_ff) + $past(nbits))
    else $error("load did not add transfer width");
  AST_STALL: assert property (img_wr && busy && (avail_ff >= need) |-> !reg_ready)
    else $error("image write not stalled");
  AST_BUSY_READ: assert property (reg_rd && (reg_addr == img_xfer_pkg::ADDR_CMD)
    |=> reg_rvalid && (reg_rdata[img_xfer_pkg::CMD_BUSY_BIT] == $past(busy)))
    else $error("busy bit wrong");
  AST_MONO_BIT: assert property (emit && mono && !line_end
    |=> avail_ff == $past(avail_ff) - 6'h01)
    else $error("mono pixel did not take one bit");
  AST_MONO_MIX: assert property (emit && mono
    |=> pix_mono && (pix_mono_bit == $past(buf_ff[0])) &&
    (pix_mix == (pix_mono_bit ? $past(fore_ff) : $past(back_ff))))
    else $error("mono mix selection wrong");
  AST_LINE32: assert property (emit && line_end &&
    (width_sel != img_xfer_pkg::XFER_PACK32) |=> avail_ff == 6'h00)
    else $error("line did not start fresh word");
  AST_PACK_BYTE: assert property (emit && line_end && !last_px &&
    (width_sel == img_xfer_pkg::XFER_PACK32) |=> avail_ff[2:0] == 3'b000)
    else $error("packed line not byte aligned");
  AST_END_BL: assert property (s_rect_done ##0 (width_sel != img_xfer_pkg::XFER_PACK32)
    |=> !busy && curpos_ff[31:16] == $past(dest_ff[31:16]) &&
    curpos_ff[15:0] == 16'($past(dest_ff[15:0]) + $past(size_ff[15:0]) + 16'h0001))
    else $error("end position not bottom-left");
  AST_END_TR: assert property (s_rect_done ##0 (width_sel == img_xfer_pkg::XFER_PACK32)
    |=> !busy && curpos_ff[15:0] == $past(dest_ff[15:0]) &&
    curpos_ff[31:16] == 16'($past(dest_ff[31:16]) + $past(size_ff[31:16]) + 16'h0001))
    else $error("end position not top-right");
  AST_START: assert property (cmd_wr && forbid |=> !busy)
    else $error("forbidden command started");
endmodule
`default_nettype wire

/* File: pkg/img_xfer_pkg.sv */
// Constants and types for the host image transfer path
package img_xfer_pkg;
  localparam logic [15:0] ADDR_CMD = 16'h9ae8;
  localparam logic [15:0] ADDR_WMASK = 16'haae8;
  localparam logic [15:0] ADDR_IMAGE = 16'h0010;
  localparam logic [15:0] ADDR_MIXSEL = 16'h0014;
  localparam logic [15:0] ADDR_FORE = 16'h0018;
  localparam logic [15:0] ADDR_BACK = 16'h001c;
  localparam logic [15:0] ADDR_SIZE = 16'h0020;
  localparam logic [15:0] ADDR_DEST = 16'h0024;
  localparam logic [15:0] ADDR_ROP = 16'h0028;
  localparam logic [15:0] ADDR_DEPTH = 16'h002c;
  localparam logic [15:0] ADDR_CURPOS = 16'h0030;
  localparam int CMD_MULTI_BIT = 1;
  localparam int CMD_DRAW_BIT = 4;
  localparam int CMD_WAIT_BIT = 8;
  localparam int CMD_BUSY_BIT = 9;
  localparam int CMD_WIDTH_LSB = 9;
  localparam int CMD_WIDTH_MSB = 10;
  localparam int MIXSEL_LSB = 6;
  localparam int MIXSEL_MSB = 7;
  localparam logic [1:0] MIXSEL_HOST = 2'h2;
  localparam int ROP_MONO_BIT = 8;
  localparam logic [15:0] RST_16 = 16'h0000;
  localparam logic [31:0] RST_32 = 32'h0000_0000;
  localparam logic [5:0] BITS_1 = 6'h01;
  localparam logic [5:0] BITS_4 = 6'h04;
  localparam logic [5:0] BITS_8 = 6'h08;
  localparam logic [5:0] BITS_16 = 6'h10;
  localparam logic [5:0] BITS_32 = 6'h20;
  typedef enum logic [1:0] {
    XFER_BYTE = 2'b00,
    XFER_WORD = 2'b01,
    XFER_LINE32 = 2'b10,
    XFER_PACK32 = 2'b11
  } xfer_type;
  typedef enum logic [1:0] {
    DEPTH_4 = 2'b00,
    DEPTH_8 = 2'b01,
    DEPTH_16 = 2'b10,
    DEPTH_32 = 2'b11
  } depth_type;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01
  } state_type;
endpackage

/* File: verification/host_cpu_model.sv */
// Host processor model driving the register port of the image path
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
  input wire logic clk_sys,
  input wire logic reg_ready,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid,
  output logic reg_wr,
  output logic reg_rd,
  output logic [15:0] reg_addr,
  output logic [31:0] reg_wdata
);
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'hffff;
    reg_wdata = 32'h5a5a_5a5a;
  end

  // Released bus shows the inverse, never a stale copy
  task automatic write(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    // Ready is combinational, so it is judged mid-cycle
    do @(negedge clk_sys); while (reg_ready !== 1'b1);
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic read(input logic [15:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(negedge clk_sys);
    d = (reg_rvalid === 1'b1) ? reg_rdata : 32'hxxxx_xxxx;
  endtask

  // Bounded poll; a hung engine shows up as a count mismatch
  task automatic wait_idle();
    logic [31:0] v;
    int n;
    n = 0;
    v = 32'hffff_ffff;
    while (v[img_xfer_pkg::CMD_BUSY_BIT] !== 1'b0 && n < 60)
    begin
      read(img_xfer_pkg::ADDR_CMD, v);
      n++;
    end
  endtask

  task automatic start_rect(input logic [1:0] dep, input logic [1:0] xf, input logic mono,
                            input logic [15:0] w, input logic [15:0] h);
    wait_idle();
    write(img_xfer_pkg::ADDR_DEPTH, {30'h0, dep});
    write(img_xfer_pkg::ADDR_MIXSEL, mono ? 32'h0000_a080 : 32'h0000_a000);
    write(img_xfer_pkg::ADDR_SIZE, {w - 16'h0001, h - 16'h0001});
    write(img_xfer_pkg::ADDR_DEST, {16'h000a, 16'h0014});
    write(img_xfer_pkg::ADDR_CMD, {16'h0000, 16'h0170 | {5'h00, xf, 9'h000}
          | {14'h0000, mono, 1'b0}});
  endtask
endmodule
`default_nettype wire

/* File: verification/host_image_transfer_raster_op_block_copy_bench.sv */
// Self-checking bench for the host image transfer path
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) \
  begin \
    checks++; \
    if ((g) !== (e)) \
    begin \
      fail_count++; \
      $display("[FAIL] %s exp %h got %h", n, e, g); \
    end \
  end
module host_image_transfer_raster_op_block_copy_bench;
  typedef struct packed {
    logic [1:0] dep;
    logic [1:0] xf;
    logic mono;
    logic [15:0] w;
    logic [15:0] h;
    logic [2:0] nw;
    logic [3:0][31:0] wd;
    logic [7:0] cnt;
    logic [31:0] first;
    logic [31:0] last;
    logic [31:0] lxy;
    logic [31:0] exy;
  } row_type;
  logic clk_sys = 1'b0;
  logic pix_ready = 1'b0;
  logic arst_n, reg_wr, reg_rd, reg_ready, reg_rvalid, pix_valid;
  logic pix_mono, pix_mono_bit;
  logic [15:0] reg_addr, pix_x, pix_y, pix_mix, pix_rop, pix_plane_mask;
  logic [31:0] reg_wdata, reg_rdata, pix_data, v;
  logic [1:0] stall_ff = 2'h0;
  logic [31:0] got_v[$];
  logic [31:0] got_xy[$];
  row_type rows [8];
  int fail_count = 0;
  int checks = 0;

  img_xfer dut (.clk_sys(clk_sys), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_ready(reg_ready),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .pix_valid(pix_valid),
    .pix_ready(pix_ready), .pix_x(pix_x), .pix_y(pix_y), .pix_data(pix_data),
    .pix_mono(pix_mono), .pix_mono_bit(pix_mono_bit), .pix_mix(pix_mix),
    .pix_rop(pix_rop), .pix_plane_mask(pix_plane_mask));
  host_cpu_model cpu (.clk_sys(clk_sys), .reg_ready(reg_ready), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata));

  always #2.5 clk_sys = ~clk_sys;

  // Memory side stalls one cycle in four to back up the unpacker
  always @(posedge clk_sys)
  begin
    stall_ff <= stall_ff + 2'h1;
    pix_ready <= (stall_ff != 2'h0);
    if (pix_valid === 1'b1 && pix_ready === 1'b1)
    begin
      // Mono entries carry a marker bit and the mono bit beside the mix
      got_v.push_back(pix_mono === 1'b1 ? {1'b1, 14'h0000, pix_mono_bit, pix_mix} : pix_data);
      got_xy.push_back({pix_x, pix_y});
    end
  end

  task automatic close_out();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic run_row(input row_type r);
    logic [31:0] p;
    int k;
    got_v.delete();
    got_xy.delete();
    cpu.start_rect(r.dep, r.xf, r.mono, r.w, r.h);
    for (k = 0; k < r.nw; k++)
      cpu.write(img_xfer_pkg::ADDR_IMAGE, r.wd[k]);
    cpu.wait_idle();
    k = 0;
    while (got_v.size() < r.cnt && k < 40)
    begin
      @(posedge clk_sys);
      k++;
    end
    `CHK("count", 32'(r.cnt), got_v.size())
    if (r.cnt != 0)
    begin
      `CHK("first", r.first, got_v[0])
      `CHK("last", r.last, got_v[$])
      `CHK("last_xy", r.lxy, got_xy[$])
    end
    cpu.read(img_xfer_pkg::ADDR_CURPOS, p);
    `CHK("end_pos", r.exy, p)
  endtask

  initial
  begin
    #100000;
    fail_count++;
    close_out();
  end

  initial
  begin
    arst_n = 1'b0;
    rows[0] = '{0, 1, 0, 3, 1, 1, {32'h0, 32'h0, 32'h0, 32'hffff_f321}, 3, 1, 3,
                32'h000c_0014, 32'h000a_0015};
    rows[1] = '{1, 2, 0, 5, 2, 4, {32'hbbbb_bbaa, 32'h9988_7766, 32'haaaa_aa55,
                32'h4433_2211}, 10, 32'h11, 32'haa, 32'h000e_0015, 32'h000a_0016};
    rows[2] = '{3, 1, 0, 1, 1, 2, {32'h0, 32'h0, 32'hffff_1234, 32'hffff_5678}, 1,
                32'h1234_5678, 32'h1234_5678, 32'h000a_0014, 32'h000a_0015};
    rows[3] = '{2, 0, 0, 2, 1, 1, {32'h0, 32'h0, 32'h0, 32'h0000_00ff}, 0, 0, 0, 0,
                32'h000a_0015};
    rows[4] = '{1, 1, 1, 9, 1, 1, {32'h0, 32'h0, 32'h0, 32'h0000_ff25}, 9,
                32'h8000_0001, 32'h8001_0002, 32'h0012_0014, 32'h000a_0015};
    rows[5] = '{1, 3, 1, 3, 3, 1, {32'h0, 32'h0, 32'h0, 32'hffdf_3fff}, 9,
                32'h8001_0002, 32'h8000_0001, 32'h000c_0016, 32'h000d_0014};
    rows[6] = '{1, 2, 1, 3, 2, 2, {32'h0, 32'h0, 32'hffff_ff5f, 32'hffff_ffbf}, 6,
                32'h8001_0002, 32'h8000_0001, 32'h000c_0015, 32'h000a_0016};
    rows[7] = '{1, 0, 0, 2, 1, 2, {32'h0, 32'h0, 32'hffff_ff22, 32'hffff_ff11}, 2,
                32'h11, 32'h22, 32'h000b_0014, 32'h000a_0015};
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    cpu.write(img_xfer_pkg::ADDR_FORE, 32'h0000_0002);
    cpu.write(img_xfer_pkg::ADDR_BACK, 32'h0000_0001);
    cpu.write(img_xfer_pkg::ADDR_ROP, 32'h0000_01cc);
    cpu.write(img_xfer_pkg::ADDR_WMASK, 32'h0000_0004);
    for (int i = 0; i < 8; i++)
      run_row(rows[i]);
    `CHK("plane_mask", 16'h0004, pix_plane_mask)
    `CHK("rop_mono", 1'b1, pix_rop[img_xfer_pkg::ROP_MONO_BIT])
    cpu.read(img_xfer_pkg::ADDR_WMASK, v);
    `CHK("wmask_rd", 16'h0004, v[15:0])
    cpu.read(16'h0040, v);
    `CHK("unmapped", 32'h0000_0000, v)
    // Second reset after the last rectangle has finished: registers must fall back
    @(posedge clk_sys);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    cpu.read(img_xfer_pkg::ADDR_CMD, v);
    `CHK("cmd_rst", 32'h0000_0000, v)
    cpu.read(img_xfer_pkg::ADDR_WMASK, v);
    `CHK("wmask_rst", 32'h0000_0000, v)
    close_out();
  end
endmodule
`default_nettype wire
